// ### hw/ext_bus_pin_sharing.sv
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module ext_bus_pin_sharing
  import ext_bus_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [REG_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [DATA_W-1:0]     avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [DATA_W-1:0]     avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  sdram_side_t                sdr_i,
  input  static_side_t               smc_i,
  input  wire logic [DATA_W-1:0]     data_in_i,
  input  wire logic                  wait_in_n_i,
  output bus_pins_t                  pins_o,
  output logic      [DATA_W-1:0]     data_to_ctrl_o,
  output logic                       wait_to_smc_n_o
);

  // ****************************************************
  // register file
  // ****************************************************
  csa_cfg_t     cfg;
  helper_pins_t helper;

  csa_reg_slave u_regs (
    .ref_clk_i         (ref_clk_i),
    .rst_i             (rst_i),
    .ce_i              (ce_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .cfg_o             (cfg)
  );

  // ****************************************************
  // nand and card helpers
  // ****************************************************
  flash_helper u_helper (
    .cfg_i    (cfg),
    .smc_i    (smc_i),
    .helper_o (helper)
  );

  // ****************************************************
  // chip select routing
  // ****************************************************
  logic [NUM_CS-1:0] cs_mux;

  generate
    for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
      if (i == SDRAM_CS) begin : g_shared
        // sdram only reaches the pin once software hands it over
        assign cs_mux[i] = cfg.cs1_owner_select ?
                           sdr_i.dram_chip_select_n :
                           smc_i.chip_select_n[i];
      end else begin : g_static
        assign cs_mux[i] = smc_i.chip_select_n[i];
      end
    end
  endgenerate

  // ****************************************************
  // pin multiplexer
  // ****************************************************
  bus_pins_t next_pins;
  logic      dram_on;

  always_comb begin
    dram_on   = sdr_i.access;
    next_pins = '0;
    next_pins.chip_select_n = cs_mux;
    // a0/a1 never see the sdram; its dqm0/dqm2 are dropped
    next_pins.addr[1:0] = smc_i.addr[1:0];
    next_pins.addr[11:2] = dram_on ? sdr_i.addr[9:0] :
                           smc_i.addr[11:2];
    next_pins.addr[12] = smc_i.addr[12];
    next_pins.addr[14:13] = dram_on ? sdr_i.addr[12:11] :
                            smc_i.addr[14:13];
    next_pins.addr[25:15] = smc_i.addr[25:15];
    next_pins.dram_addr10 = sdr_i.addr[10];
    next_pins.write_strobe_n[0] = dram_on ? 1'b1 :
                                  smc_i.write_strobe_n[0];
    next_pins.write_strobe_n[1] = dram_on ?
      sdr_i.byte_mask_n[1] :
      (smc_i.write_strobe_n[1] & smc_i.upper_byte_sel_n);
    next_pins.write_strobe_n[2] = smc_i.write_strobe_n[2];
    next_pins.write_strobe_n[3] = dram_on ?
      sdr_i.byte_mask_n[3] : smc_i.write_strobe_n[3];
    next_pins.read_strobe_n = dram_on ? 1'b1 :
                              smc_i.read_strobe_n;
    next_pins.dram_ras_n = sdr_i.dram_ras_n;
    next_pins.dram_cas_n = sdr_i.dram_cas_n;
    next_pins.dram_write_enable_n =
      sdr_i.dram_write_enable_n;
    next_pins.dram_clock_enable = sdr_i.dram_clock_enable;
    next_pins.data_out = dram_on ? sdr_i.dout :
                         smc_i.dout;
    next_pins.data_oe  = dram_on ? sdr_i.doe : smc_i.doe;
    next_pins.data_pullup_en =
      !cfg.data_bus_pullup_disable;
    next_pins.helper = helper;
  end

  // ****************************************************
  // pin and return registers
  // ****************************************************
  // one register stage keeps every pin glitch free; costs a cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o <= '{
        chip_select_n       : '1,
        addr                : '0,
        dram_addr10         : 1'b0,
        write_strobe_n      : '1,
        read_strobe_n       : 1'b1,
        dram_ras_n          : 1'b1,
        dram_cas_n          : 1'b1,
        dram_write_enable_n : 1'b1,
        dram_clock_enable   : 1'b0,
        data_out            : '0,
        data_oe             : 1'b0,
        data_pullup_en      : 1'b1,
        helper              : '1
      };
      data_to_ctrl_o  <= '0;
      wait_to_smc_n_o <= 1'b1;
    end else if (ce_i) begin
      pins_o          <= next_pins;
      data_to_ctrl_o  <= data_in_i;
      wait_to_smc_n_o <= wait_in_n_i;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  a_cs1_sdram_owner: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) && $past(cfg.cs1_owner_select) |->
      pins_o.chip_select_n[SDRAM_CS] ==
      $past(sdr_i.dram_chip_select_n))
    else $error("cs1 not from sdram while owned");

  a_cs1_static_owner: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) && !$past(cfg.cs1_owner_select) |->
      pins_o.chip_select_n[SDRAM_CS] ==
      $past(smc_i.chip_select_n[SDRAM_CS]))
    else $error("cs1 not from static controller");

  a_nand_gated: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) && !$past(cfg.cs3_nand_logic_enable) |->
      pins_o.helper.nand_chip_select_n &&
      pins_o.helper.nand_output_enable_n &&
      pins_o.helper.nand_write_enable_n)
    else $error("nand strobe active while disabled");

  a_card_slot1: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) |->
      pins_o.helper.card_slot_select_n[0] ==
      !($past(cfg.cs4_card_slot1_enable) &&
        !$past(smc_i.chip_select_n[CARD0_CS])))
    else $error("card slot one select wrong");

  a_card_slot2: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) |->
      pins_o.helper.card_slot_select_n[1] ==
      !($past(cfg.cs5_card_slot2_enable) &&
        !$past(smc_i.chip_select_n[CARD1_CS])))
    else $error("card slot two select wrong");

  a_pullup_level: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) |->
      pins_o.data_pullup_en == !$past(cfg.data_bus_pullup_disable))
    else $error("pull-up request inverted");

  a_static_cs: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) |->
      pins_o.chip_select_n[NUM_CS-1:SDRAM_CS+1] ==
      $past(smc_i.chip_select_n[NUM_CS-1:SDRAM_CS+1]) &&
      pins_o.chip_select_n[0] == $past(smc_i.chip_select_n[0]))
    else $error("static chip select not routed");

  a_write1_pin: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) && $past(sdr_i.access) |->
      pins_o.write_strobe_n[1] == $past(sdr_i.byte_mask_n[1]))
    else $error("write-1 pin not byte mask");

  a_low_addr: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) |-> pins_o.addr[1:0] == $past(smc_i.addr[1:0]))
    else $error("address 0/1 not static");

  a_dram_addr_low: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) && $past(sdr_i.access) |->
      pins_o.addr[11:2] == $past(sdr_i.addr[9:0]))
    else $error("sdram low address misrouted");

  a_dram_addr_high: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) && $past(sdr_i.access) |->
      pins_o.addr[14:13] == $past(sdr_i.addr[12:11]) &&
      pins_o.addr[12] == $past(smc_i.addr[12]))
    else $error("sdram high address misrouted");

  a_addr10_pin: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $past(ce_i) |-> pins_o.dram_addr10 == $past(sdr_i.addr[10]))
    else $error("dram address 10 wrong");

  a_reset_idle: assert property (
    @(posedge ref_clk_i)
    rst_i |=> rst_i |-> pins_o.dram_ras_n && pins_o.dram_cas_n &&
      !pins_o.dram_clock_enable && (&pins_o.chip_select_n))
    else $error("strobes not idle in reset");

  a_freeze_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !$past(ce_i) && !$past(rst_i) |-> $stable(pins_o))
    else $error("pins moved while clock enable low");

endmodule

// ### hw/ext_bus_pkg.sv
package ext_bus_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int NUM_CS      = 8;
  localparam int ADDR_PINS   = 26;
  localparam int DATA_W      = 32;
  localparam int DRAM_ADDR_W = 13;
  localparam int STROBES     = 4;
  localparam int REG_ADDR_W  = 8;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [REG_ADDR_W-1:0] CSA_OFFSET = 8'h00;
  localparam logic [DATA_W-1:0]     CSA_RESET  = 32'h0000_0000;

  localparam int CS1_BIT   = 1;
  localparam int CS3_BIT   = 3;
  localparam int CS4_BIT   = 4;
  localparam int CS5_BIT   = 5;
  localparam int DBPUC_BIT = 8;

  localparam logic [DATA_W-1:0] CSA_RW_MASK =
    (32'h1 << CS1_BIT) | (32'h1 << CS3_BIT) | (32'h1 << CS4_BIT) |
    (32'h1 << CS5_BIT) | (32'h1 << DBPUC_BIT);

  // chip select lines with extra duties
  localparam int SDRAM_CS = 1;
  localparam int NAND_CS  = 3;
  localparam int CARD0_CS = 4;
  localparam int CARD1_CS = 5;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic cs1_owner_select;
    logic cs3_nand_logic_enable;
    logic cs4_card_slot1_enable;
    logic cs5_card_slot2_enable;
    logic data_bus_pullup_disable;
  } csa_cfg_t;

  typedef struct packed {
    logic                   access;
    logic                   dram_chip_select_n;
    logic                   dram_ras_n;
    logic                   dram_cas_n;
    logic                   dram_write_enable_n;
    logic                   dram_clock_enable;
    logic [DRAM_ADDR_W-1:0] addr;
    logic [STROBES-1:0]     byte_mask_n;
    logic [DATA_W-1:0]      dout;
    logic                   doe;
  } sdram_side_t;

  typedef struct packed {
    logic [NUM_CS-1:0]    chip_select_n;
    logic [ADDR_PINS-1:0] addr;
    logic [STROBES-1:0]   write_strobe_n;
    logic                 upper_byte_sel_n;
    logic                 read_strobe_n;
    logic                 io_access;
    logic [DATA_W-1:0]    dout;
    logic                 doe;
  } static_side_t;

  typedef struct packed {
    logic       nand_chip_select_n;
    logic       nand_output_enable_n;
    logic       nand_write_enable_n;
    logic [1:0] card_chip_enable_n;
    logic       card_output_enable_n;
    logic       card_write_enable_n;
    logic       card_io_read_n;
    logic       card_io_write_n;
    logic       card_read_not_write;
    logic [1:0] card_slot_select_n;
  } helper_pins_t;

  typedef struct packed {
    logic [NUM_CS-1:0]    chip_select_n;
    logic [ADDR_PINS-1:0] addr;
    logic                 dram_addr10;
    logic [STROBES-1:0]   write_strobe_n;
    logic                 read_strobe_n;
    logic                 dram_ras_n;
    logic                 dram_cas_n;
    logic                 dram_write_enable_n;
    logic                 dram_clock_enable;
    logic [DATA_W-1:0]    data_out;
    logic                 data_oe;
    logic                 data_pullup_en;
    helper_pins_t         helper;
  } bus_pins_t;

  function automatic logic field_bit(logic [DATA_W-1:0] r, int pos);
    field_bit = r[pos];
  endfunction

endpackage

// ### hw/csa_reg_slave.sv
`timescale 1ns/1ps
module csa_reg_slave
  import ext_bus_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [REG_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [DATA_W-1:0]     avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [DATA_W-1:0]     avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output csa_cfg_t                   cfg_o
);

  logic [DATA_W-1:0] csa;
  logic [DATA_W-1:0] next_csa;
  logic [DATA_W-1:0] next_rdata;
  logic              next_wait;
  logic [DATA_W-1:0] be_mask;
  logic              hit;

  always_comb begin
    be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    hit        = (avs_address_i == CSA_OFFSET);
    next_csa   = csa;
    next_rdata = avs_readdata_o;
    next_wait  = 1'b1;
    // one wait cycle, then a single-cycle answer
    if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      next_wait  = 1'b0;
      next_rdata = hit ? (csa & CSA_RW_MASK) : '0;
    end
    if (avs_write_i && !avs_waitrequest_o && hit) begin
      next_csa = (csa & ~(be_mask & CSA_RW_MASK)) |
                 (avs_writedata_i & be_mask & CSA_RW_MASK);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      csa               <= CSA_RESET;
      avs_readdata_o    <= '0;
      avs_waitrequest_o <= 1'b1;
      cfg_o             <= '0;
    end else if (ce_i) begin
      csa               <= next_csa;
      avs_readdata_o    <= next_rdata;
      avs_waitrequest_o <= next_wait;
      cfg_o.cs1_owner_select        <= field_bit(next_csa, CS1_BIT);
      cfg_o.cs3_nand_logic_enable   <= field_bit(next_csa, CS3_BIT);
      cfg_o.cs4_card_slot1_enable   <= field_bit(next_csa, CS4_BIT);
      cfg_o.cs5_card_slot2_enable   <= field_bit(next_csa, CS5_BIT);
      cfg_o.data_bus_pullup_disable <= field_bit(next_csa, DBPUC_BIT);
    end
  end

  a_reserved_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !avs_waitrequest_o |-> (avs_readdata_o & ~CSA_RW_MASK) == '0)
    else $error("reserved register bits read non-zero");

endmodule

// ### hw/flash_helper.sv
`timescale 1ns/1ps
module flash_helper
  import ext_bus_pkg::*;
(
  input  csa_cfg_t     cfg_i,
  input  static_side_t smc_i,
  output helper_pins_t helper_o
);

  logic nand_sel;
  logic card0;
  logic card1;
  logic card;
  logic rd;
  logic wr;

  always_comb begin
    rd       = !smc_i.read_strobe_n;
    wr       = !smc_i.write_strobe_n[0];
    // disabled helpers keep every strobe idle high
    nand_sel = cfg_i.cs3_nand_logic_enable &&
               !smc_i.chip_select_n[NAND_CS];
    card0    = cfg_i.cs4_card_slot1_enable &&
               !smc_i.chip_select_n[CARD0_CS];
    card1    = cfg_i.cs5_card_slot2_enable &&
               !smc_i.chip_select_n[CARD1_CS];
    card     = card0 || card1;
    helper_o.nand_chip_select_n   = !nand_sel;
    helper_o.nand_output_enable_n = !(nand_sel && rd);
    helper_o.nand_write_enable_n  = !(nand_sel && wr);
    helper_o.card_slot_select_n   = {!card1, !card0};
    helper_o.card_chip_enable_n[0] = !card;
    helper_o.card_chip_enable_n[1] =
      !(card && !smc_i.upper_byte_sel_n);
    helper_o.card_output_enable_n = !(card && !smc_i.io_access && rd);
    helper_o.card_write_enable_n  = !(card && !smc_i.io_access && wr);
    helper_o.card_io_read_n       = !(card && smc_i.io_access && rd);
    helper_o.card_io_write_n      = !(card && smc_i.io_access && wr);
    helper_o.card_read_not_write  = !wr;
  end

endmodule

// ### verification/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  bus_pins_t              pins_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   wait_n_o
);
  // ****************************************************
  // slow device: holds off each read for three cycles
  // ****************************************************
  logic [DATA_W-1:0] last;
  logic [1:0]        hold;
  logic              rd_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last <= '0;
      hold <= 2'h0;
      rd_q <= 1'b1;
    end else begin
      rd_q <= pins_i.read_strobe_n;
      if (pins_i.data_oe) begin
        last <= pins_i.data_out;
      end
      if (rd_q && !pins_i.read_strobe_n && pins_i.chip_select_n != '1) begin
        hold <= 2'h3;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end
    end
  end

  // released lines show the inverse of the last value, with bits 15:0 driven to FFFF while data_pullup_en is set
  always_comb begin
    wait_n_o = (hold == 2'h0);
    data_o   = pins_i.data_oe ? pins_i.data_out : ~last;
    if (!pins_i.data_oe && pins_i.data_pullup_en) begin
      data_o[15:0] = 16'hFFFF;
    end
  end
endmodule

// ### verification/ext_bus_pin_sharing_bench.sv
`timescale 1ns/1ps
module ext_bus_pin_sharing_bench import ext_bus_pkg::*;;
  logic                  ref_clk;
  logic                  rst;
  logic                  ce;
  logic [REG_ADDR_W-1:0] address;
  logic                  read;
  logic                  write;
  logic [DATA_W-1:0]     wdata;
  logic [DATA_W-1:0]     rdata;
  logic [DATA_W-1:0]     got;
  logic [3:0]            be;
  logic                  waitreq;
  sdram_side_t           sdr;
  static_side_t          static_mem_ctrl;
  logic [DATA_W-1:0]     data_in;
  logic [DATA_W-1:0]     data_to_ctrl;
  logic                  wait_n;
  logic                  wait_to_smc_n;
  logic                  seen_wait;
  bus_pins_t             pins;
  int                    n_fail;
  int                    checks;

  always #2 ref_clk = ~ref_clk;

  ext_bus_pin_sharing dut (
    .ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce),
    .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .sdr_i(sdr), .smc_i(static_mem_ctrl), .data_in_i(data_in), .wait_in_n_i(wait_n),
    .pins_o(pins), .data_to_ctrl_o(data_to_ctrl),
    .wait_to_smc_n_o(wait_to_smc_n)
  );

  ext_mem_model mem (
    .ref_clk_i(ref_clk), .rst_i(rst), .pins_i(pins),
    .data_o(data_in), .wait_n_o(wait_n)
  );

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus_cycle(input logic wr, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge ref_clk);
    address <= a;
    wdata   <= d;
    be      <= b;
    write   <= wr;
    read    <= !wr;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (waitreq === 1'b0) break;
    end
    got = rdata;
    write <= 1'b0;
    read  <= 1'b0;
    if (k == 20) begin
      n_fail++;
      complete_run();
    end
  endtask

  // config reaches pins two edges after the answer
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic set_cfg(input logic [31:0] v);
    bus_cycle(1'b1, CSA_OFFSET, v, 4'hF);
    settle();
  endtask

  initial begin
    ref_clk = 1'b0; rst = 1'b1; read = 1'b0; write = 1'b0;
    ce = 1'b1;
    address = '0; wdata = '0; be = 4'h0; n_fail = 0; checks = 0;
    sdr = '0; sdr.dram_chip_select_n = 1'b1; sdr.dram_ras_n = 1'b1;
    sdr.dram_cas_n = 1'b1; sdr.dram_write_enable_n = 1'b1;
    sdr.byte_mask_n = 4'hF;
    static_mem_ctrl = '0; static_mem_ctrl.chip_select_n = 8'hFF; static_mem_ctrl.write_strobe_n = 4'hF;
    static_mem_ctrl.upper_byte_sel_n = 1'b1; static_mem_ctrl.read_strobe_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check(pins.dram_ras_n, 1'b1);
    check(pins.dram_clock_enable, 1'b0);
    check(pins.data_pullup_en, 1'b1);
    check(pins.helper.nand_chip_select_n, 1'b1);
    @(posedge ref_clk);
    rst <= 1'b0;
    // ****************************************************
    // register
    // ****************************************************
    bus_cycle(1'b0, CSA_OFFSET, '0, 4'hF);
    check(got, 32'h0000_0000);
    bus_cycle(1'b1, CSA_OFFSET, 32'hFFFF_FFFF, 4'hF);
    bus_cycle(1'b0, CSA_OFFSET, '0, 4'hF);
    check(got, 32'h0000_013A);
    bus_cycle(1'b1, 8'h04, 32'h0000_0000, 4'hF);
    bus_cycle(1'b0, 8'h04, '0, 4'hF);
    check(got, 32'h0000_0000);
    bus_cycle(1'b0, CSA_OFFSET, '0, 4'hF);
    check(got, 32'h0000_013A);
    bus_cycle(1'b1, CSA_OFFSET, 32'h0000_0000, 4'h1);
    bus_cycle(1'b0, CSA_OFFSET, '0, 4'hF);
    check(got, 32'h0000_0100);
    settle();
    check(pins.data_pullup_en, 1'b0);
    set_cfg(32'h0);
    check(pins.data_pullup_en, 1'b1);
    check(data_to_ctrl[15:0], 16'hFFFF);
    // ****************************************************
    // chip selects
    // ****************************************************
    for (int i = 0; i < NUM_CS; i++) begin
      @(posedge ref_clk);
      static_mem_ctrl.chip_select_n <= ~(8'h01 << i);
      settle();
      check(pins.chip_select_n, 8'(~(8'h01 << i)));
    end
    @(posedge ref_clk);
    static_mem_ctrl.chip_select_n <= 8'hFF;
    sdr.dram_chip_select_n <= 1'b0;
    settle();
    check(pins.chip_select_n[1], 1'b1);
    set_cfg(32'h2);
    check(pins.chip_select_n[1], 1'b0);
    set_cfg(32'h0);
    // ****************************************************
    // address, strobes and data sharing
    // ****************************************************
    // clock enable low: new addresses must not reach the pins
    @(posedge ref_clk);
    ce <= 1'b0;
    static_mem_ctrl.addr <= 26'h2ABCDEF;
    sdr.addr <= 13'h0EBC;
    settle();
    check(pins.addr, 26'h0000000);
    @(posedge ref_clk);
    ce <= 1'b1;
    settle();
    check(pins.addr, 26'h2ABCDEF);
    @(posedge ref_clk);
    sdr.access <= 1'b1;
    sdr.byte_mask_n <= 4'h5;
    sdr.dram_ras_n <= 1'b0;
    sdr.dram_write_enable_n <= 1'b0;
    sdr.dram_clock_enable <= 1'b1;
    sdr.doe <= 1'b1;
    sdr.dout <= 32'h1234_5678;
    static_mem_ctrl.write_strobe_n <= 4'hE;
    settle();
    check(pins.write_strobe_n[0], 1'b1);
    check(pins.addr[11:2], sdr.addr[9:0]);
    check(pins.addr[14:13], sdr.addr[12:11]);
    check(pins.dram_addr10, sdr.addr[10]);
    check(pins.addr[25:15], static_mem_ctrl.addr[25:15]);
    check(pins.addr[12], static_mem_ctrl.addr[12]);
    check(pins.addr[1], static_mem_ctrl.addr[1]);
    check(pins.write_strobe_n[1], 1'b0);
    check({pins.dram_ras_n, pins.dram_cas_n}, 2'b01);
    check(pins.dram_write_enable_n, 1'b0);
    check(pins.dram_clock_enable, 1'b1);
    check({pins.data_oe, pins.data_out}, {1'b1, 32'h1234_5678});
    check(data_to_ctrl, 32'h1234_5678);
    @(posedge ref_clk);
    sdr.access <= 1'b0;
    sdr.doe <= 1'b0;
    static_mem_ctrl.upper_byte_sel_n <= 1'b0;
    static_mem_ctrl.write_strobe_n <= 4'hF;
    settle();
    check(pins.write_strobe_n[1], 1'b0);
    check(pins.data_oe, 1'b0);
    // ****************************************************
    // nand helper and wait input
    // ****************************************************
    set_cfg(32'h8);
    @(posedge ref_clk);
    static_mem_ctrl.upper_byte_sel_n <= 1'b1;
    static_mem_ctrl.chip_select_n <= 8'hF7;
    static_mem_ctrl.read_strobe_n <= 1'b0;
    seen_wait = 1'b0;
    for (int k = 0; k < 10; k++) begin
      @(posedge ref_clk);
      #1;
      if (wait_to_smc_n === 1'b0) seen_wait = 1'b1;
    end
    check(seen_wait, 1'b1);
    check(wait_to_smc_n, 1'b1);
    check(pins.helper.nand_chip_select_n, 1'b0);
    check(pins.helper.nand_output_enable_n, 1'b0);
    check(pins.helper.nand_write_enable_n, 1'b1);
    check(pins.chip_select_n[3], 1'b0);
    check(pins.read_strobe_n, 1'b0);
    set_cfg(32'h0);
    check(pins.helper.nand_chip_select_n, 1'b1);
    // ****************************************************
    // card slots
    // ****************************************************
    set_cfg(32'h30);
    @(posedge ref_clk);
    static_mem_ctrl.chip_select_n <= 8'hEF;
    static_mem_ctrl.write_strobe_n <= 4'hE;
    settle();
    check(pins.helper.card_slot_select_n, 2'b10);
    check(pins.helper.card_chip_enable_n[0], 1'b0);
    check(pins.helper.card_output_enable_n, 1'b0);
    check(pins.helper.card_read_not_write, 1'b0);
    check(pins.helper.card_write_enable_n, 1'b0);
    check(pins.helper.card_chip_enable_n[1], 1'b1);
    check(pins.chip_select_n[4], 1'b0);
    @(posedge ref_clk);
    static_mem_ctrl.chip_select_n <= 8'hDF;
    static_mem_ctrl.io_access <= 1'b1;
    static_mem_ctrl.write_strobe_n <= 4'hF;
    settle();
    check(pins.helper.card_slot_select_n, 2'b01);
    check(pins.helper.card_io_read_n, 1'b0);
    check(pins.helper.card_read_not_write, 1'b1);
    check(pins.helper.card_io_write_n, 1'b1);
    check(pins.chip_select_n[5], 1'b0);
    complete_run();
  end
endmodule
